// [design/sirs_defs.svh]
// Constants for the two-wire register slave: address, index fields and timing.
// Assumes a 50 MHz system clock sampling the bus lines.
`ifndef SIRS_DEFS_SVH
`define SIRS_DEFS_SVH

`define SIRS_ADDR_UPPER      6'h2e
`define SIRS_AUTOINC_BIT     7
`define SIRS_REG_COUNT       128
`define SIRS_CLK_HZ          50000000
`define SIRS_SCL_MAX_HZ      400000
`define SIRS_CLK_PER_SCL     (`SIRS_CLK_HZ / `SIRS_SCL_MAX_HZ)
`define SIRS_STRETCH_CYCLES  4'h4

`endif

// [design/sirs_pkg.sv]
// Types shared by the two-wire register slave files.
// Assumes nothing beyond the defines header.
package sirs_pkg;

  typedef enum logic [3:0] {
    PH_IDLE,
    PH_ADDR,
    PH_ADDR_ACK,
    PH_INDEX,
    PH_INDEX_ACK,
    PH_WDATA,
    PH_WDATA_ACK,
    PH_RDATA,
    PH_RDATA_ACK,
    PH_IGNORE
  } sirs_state_t;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] wdata;
  } sirs_mem_req_t;

endpackage

// [design/sirs_regbank.sv]
// Register bank of 128 bytes with a registered read port.
// Assumes requests come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "sirs_defs.svh"

module sirs_regbank (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   reset,
  // Access request
  input  wire sirs_pkg::sirs_mem_req_t req,
  // Read data
  output logic [7:0]                  rdata
);

  logic [7:0] mem [0:`SIRS_REG_COUNT-1];

  // Contents are not reset; the bank only holds what the master writes.
  always_ff @(posedge clock) begin
    if (req.we) begin
      mem[req.addr] <= req.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[req.addr];
    end
  end

endmodule

`default_nettype wire

// [design/sirs_slave.sv]
// Two-wire serial slave giving a bus master access to the 8-bit register bank.
// Assumes the bus lines and straps arrive asynchronously; SCL runs at most 400 kHz.
`timescale 1ns/10ps
`default_nettype none
`include "sirs_defs.svh"

// Overview of operation
// - Slave active only while interface select high.
// - Address 101110 plus strapped low bit.
// - Match seven bits; eighth bit sets direction.
// - Start is data falling with clock high.
// - Stop is data rising with clock high.
// - Receiver holds data low during ninth clock.
// - Acknowledge address, index and written bytes.
// - Index byte: seven address bits, increment flag.
// - Increment flag advances address each acknowledged data byte.
// - Writes: address, index, data bytes, stop.
// - Send read bytes until master withholds acknowledge.
// - Eight bits per byte, most significant first.
// - Stretch clock low while next byte prepares.
// - Unmatched address leaves data line released.
// - Works with bus clocks up to 400 kHz.
module sirs_slave (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // Bus clock line, open drain
  input  wire logic scl_in,
  output logic      scl_out,
  output logic      scl_oe_n,
  // Bus data line, open drain
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n,
  // Straps
  input  wire logic interface_select,
  input  wire logic address_lsb_strap,
  // Status
  output logic      bus_busy_reg,
  output logic      selected_reg
);

  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [1:0] sel_sync_reg;
  logic [1:0] lsb_sync_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;
  logic       start_seen;
  logic       stop_seen;
  logic       scl_rise;
  logic       scl_fall;
  logic       scl_s;
  logic       sda_s;
  logic       active;
  logic       got_bit_reg;
  logic       byte_end;
  logic       ack_end;

  sirs_pkg::sirs_state_t state_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic [6:0] index_reg;
  logic       autoinc_reg;
  logic       read_dir_reg;
  logic       sda_low_reg;
  logic [3:0] stretch_reg;
  logic       load_pending_reg;
  logic [7:0] rdata;
  sirs_pkg::sirs_mem_req_t req;

  // Two flip-flops on every pin before any logic looks at it.
  always_ff @(posedge clock) begin
    if (reset) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      sel_sync_reg <= 2'h0;
      lsb_sync_reg <= 2'h0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      sel_sync_reg <= {sel_sync_reg[0], interface_select};
      lsb_sync_reg <= {lsb_sync_reg[0], address_lsb_strap};
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end

  // At 50 MHz a 400 kHz bus clock gives over a hundred samples per period.
  assign scl_s      = scl_sync_reg[1];
  assign sda_s      = sda_sync_reg[1];
  assign active     = sel_sync_reg[1];
  assign scl_rise   = scl_s & ~scl_d_reg;
  assign scl_fall   = ~scl_s & scl_d_reg;
  assign start_seen = active & scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_seen  = active & scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  always_ff @(posedge clock) begin
    if (reset) begin
      bus_busy_reg <= 1'b0;
    end else if (!active || stop_seen) begin
      bus_busy_reg <= 1'b0;
    end else if (start_seen) begin
      bus_busy_reg <= 1'b1;
    end
  end

  // A received byte ends on the fall after eight rises; an acknowledge ends on the next fall.
  assign byte_end = scl_fall & got_bit_reg & (bit_cnt_reg == 3'h0) & ~sda_low_reg;
  assign ack_end  = scl_fall & sda_low_reg & (state_reg == sirs_pkg::PH_ADDR_ACK
                                              || state_reg == sirs_pkg::PH_INDEX_ACK
                                              || state_reg == sirs_pkg::PH_WDATA_ACK);

  // The fall that follows a start also finds the bit counter at zero, so a
  // byte only counts as complete once at least one bit has been shifted in.
  always_ff @(posedge clock) begin
    if (reset || !active || start_seen || stop_seen) begin
      got_bit_reg <= 1'b0;
    end else if (byte_end) begin
      got_bit_reg <= 1'b0;
    end else if (scl_rise && (state_reg == sirs_pkg::PH_ADDR || state_reg == sirs_pkg::PH_INDEX
                              || state_reg == sirs_pkg::PH_WDATA)) begin
      got_bit_reg <= 1'b1;
    end
  end

  // Byte sequencer. A start from any state, including mid-read, restarts the
  // address phase, which gives the repeated start of a read.
  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg    <= sirs_pkg::PH_IDLE;
      shift_reg    <= 8'h00;
      bit_cnt_reg  <= 3'h0;
      read_dir_reg <= 1'b0;
      selected_reg <= 1'b0;
      sda_low_reg  <= 1'b0;
    end else if (!active || stop_seen) begin
      state_reg    <= sirs_pkg::PH_IDLE;
      selected_reg <= 1'b0;
      sda_low_reg  <= 1'b0;
    end else if (start_seen) begin
      state_reg    <= sirs_pkg::PH_ADDR;
      bit_cnt_reg  <= 3'h0;
      selected_reg <= 1'b0;
      sda_low_reg  <= 1'b0;
    end else begin
      unique case (state_reg)
        sirs_pkg::PH_IDLE, sirs_pkg::PH_IGNORE: begin
          sda_low_reg <= 1'b0;
        end
        sirs_pkg::PH_ADDR, sirs_pkg::PH_INDEX, sirs_pkg::PH_WDATA: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
          end
        end
        default: begin
        end
      endcase
      // Ninth-clock handling shared by all receive states.
      if (byte_end) begin
        unique case (state_reg)
          sirs_pkg::PH_ADDR: begin
            if (shift_reg[7:1] == {`SIRS_ADDR_UPPER, lsb_sync_reg[1]}) begin
              read_dir_reg <= shift_reg[0];
              selected_reg <= 1'b1;
              sda_low_reg  <= 1'b1;
              state_reg    <= sirs_pkg::PH_ADDR_ACK;
            end else begin
              state_reg    <= sirs_pkg::PH_IGNORE;
            end
          end
          sirs_pkg::PH_INDEX: begin
            sda_low_reg  <= 1'b1;
            state_reg    <= sirs_pkg::PH_INDEX_ACK;
          end
          sirs_pkg::PH_WDATA: begin
            sda_low_reg  <= 1'b1;
            state_reg    <= sirs_pkg::PH_WDATA_ACK;
          end
          default: begin
          end
        endcase
      end
      // End of the acknowledge clock: release, or drive the first read bit, and move on.
      if (ack_end) begin
        bit_cnt_reg <= 3'h0;
        if (state_reg == sirs_pkg::PH_ADDR_ACK && read_dir_reg) begin
          sda_low_reg <= ~rdata[7];
          shift_reg   <= {rdata[6:0], 1'b0};
          bit_cnt_reg <= 3'h1;
          state_reg   <= sirs_pkg::PH_RDATA;
        end else begin
          sda_low_reg <= 1'b0;
          state_reg   <= (state_reg == sirs_pkg::PH_ADDR_ACK) ? sirs_pkg::PH_INDEX : sirs_pkg::PH_WDATA;
        end
      end
      // Read path: shift out on falling edges, then sample the master's answer.
      if (state_reg == sirs_pkg::PH_RDATA && scl_fall) begin
        if (bit_cnt_reg == 3'h0) begin
          sda_low_reg <= 1'b0;
          state_reg   <= sirs_pkg::PH_RDATA_ACK;
        end else begin
          sda_low_reg <= ~shift_reg[7];
          shift_reg   <= {shift_reg[6:0], 1'b0};
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
      end
      if (state_reg == sirs_pkg::PH_RDATA_ACK && scl_rise && sda_s) begin
        state_reg <= sirs_pkg::PH_IGNORE;
      end
      // Only an acknowledged ninth clock is still here at its fall.
      if (state_reg == sirs_pkg::PH_RDATA_ACK && scl_fall) begin
        sda_low_reg <= ~rdata[7];
        shift_reg   <= {rdata[6:0], 1'b0};
        bit_cnt_reg <= 3'h1;
        state_reg   <= sirs_pkg::PH_RDATA;
      end
    end
  end

  // Register index: loaded from the index byte, stepped per acknowledged data byte when the flag is set.
  always_ff @(posedge clock) begin
    if (reset) begin
      index_reg   <= 7'h00;
      autoinc_reg <= 1'b0;
    end else if (active && !stop_seen && !start_seen) begin
      if (byte_end && state_reg == sirs_pkg::PH_INDEX) begin
        index_reg   <= shift_reg[6:0];
        autoinc_reg <= shift_reg[`SIRS_AUTOINC_BIT];
      end else if (ack_end && state_reg == sirs_pkg::PH_WDATA_ACK && autoinc_reg) begin
        index_reg <= index_reg + 7'h01;
      end else if (state_reg == sirs_pkg::PH_RDATA_ACK && scl_rise && !sda_s && autoinc_reg) begin
        index_reg <= index_reg + 7'h01;
      end
    end
  end

  // Memory access: a write lands as its acknowledge begins; the read address follows the index.
  always_comb begin
    req.we    = (state_reg == sirs_pkg::PH_WDATA) && byte_end;
    req.addr  = index_reg;
    req.wdata = shift_reg;
  end

  // After the master acknowledges a read byte the index may have just moved,
  // so the bus clock is held low a few cycles past the next fall. The stretch
  // is short on purpose; it costs little bus time at 400 kHz.
  always_ff @(posedge clock) begin
    if (reset || !active || start_seen || stop_seen) begin
      stretch_reg      <= 4'h0;
      load_pending_reg <= 1'b0;
    end else if (state_reg == sirs_pkg::PH_RDATA_ACK && scl_rise && !sda_s) begin
      load_pending_reg <= 1'b1;
    end else if (load_pending_reg && scl_fall) begin
      stretch_reg      <= `SIRS_STRETCH_CYCLES;
      load_pending_reg <= 1'b0;
    end else if (stretch_reg != 4'h0) begin
      stretch_reg <= stretch_reg - 4'h1;
    end
  end

  sirs_regbank u_bank (
    .clock (clock),
    .reset (reset),
    .req   (req),
    .rdata (rdata)
  );

  // Open-drain drivers: enable is low while the line is pulled down.
  always_ff @(posedge clock) begin
    if (reset) begin
      sda_out  <= 1'b0;
      sda_oe_n <= 1'b1;
      scl_out  <= 1'b0;
      scl_oe_n <= 1'b1;
    end else begin
      sda_out  <= 1'b0;
      sda_oe_n <= ~(sda_low_reg & active);
      scl_out  <= 1'b0;
      scl_oe_n <= ~((stretch_reg != 4'h0) & active);
    end
  end

endmodule

`default_nettype wire

// [dv/sirs_mst.sv]
// Behavioural two-wire bus master.
// Assumes pull-ups on both lines; a low enable pulls its line low.
`timescale 1ns/10ps
`default_nettype none

module sirs_mst #(
  parameter int P = 160
) (
  // Resolved lines
  input  wire logic  scl,
  input  wire logic  sda,
  // Pull-downs
  output logic       scl_oe_n = 1'b1,
  output logic       sda_oe_n = 1'b1,
  // One result per byte
  output logic       res_stb = 1'b0,
  output logic [7:0] res_val = 8'h00
);
  // Waiting on the line lets a stretching slave stall us.
  task automatic frame(input logic a, input logic b);
    sda_oe_n = a;
    #(P);
    scl_oe_n = 1'b1;
    wait (scl === 1'b1);
    #(P);
    sda_oe_n = b;
    #(P);
  endtask

  // Data moves only with SCL low; ninth clock is the acknowledge.
  task automatic xbyte(input logic [8:0] d, input logic rd);
    logic [8:0] v;
    for (int i = 8; i >= 0; i--) begin
      frame(d[i], d[i]);
      v[i] = sda;
      scl_oe_n = 1'b0;
      #(P / 4);
    end
    res_val = rd ? v[8:1] : {7'h00, v[0]};
    res_stb = 1'b1;
    #1;
    res_stb = 1'b0;
  endtask

  task automatic start();
    frame(1'b1, 1'b0);
    scl_oe_n = 1'b0;
    #(P / 4);
  endtask

  task automatic stop();
    frame(1'b0, 1'b1);
  endtask
endmodule

`default_nettype wire

// [dv/sirs_slave_assertions.sv]
// Port checks for the two-wire register slave.
// Assumes each SCL phase spans at least eight clocks.
`timescale 1ns/10ps
`default_nettype none

module sirs_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Bus lines
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // Straps and status
  input wire logic interface_select,
  input wire logic address_lsb_strap,
  input wire logic bus_busy_reg,
  input wire logic selected_reg
);
  logic [3:0] hold_reg;

  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);

  // Saturates so a stuck stretch cannot wrap back into range.
  always_ff @(posedge clock) begin
    if (reset || scl_oe_n) begin
      hold_reg <= 4'h0;
    end else if (hold_reg != 4'hf) begin
      hold_reg <= hold_reg + 4'h1;
    end
  end

  a_lines_only_pull: assert property (!sda_out && !scl_out)
    else $error("line driven high");
  a_unselected_quiet: assert property (!interface_select [*6] |-> sda_oe_n && scl_oe_n)
    else $error("driving while deselected");
  a_start_busy: assert property ($fell(sda_in) && scl_in && $past(scl_in) && interface_select
    |-> ##[1:6] bus_busy_reg) else $error("start not seen");
  a_stop_idle: assert property ($rose(sda_in) && scl_in && $past(scl_in)
    |-> ##[1:6] !bus_busy_reg && !selected_reg) else $error("stop not seen");
  a_ack_steady: assert property ((interface_select && scl_in) [*8] |-> $stable(sda_oe_n))
    else $error("data moved while clock high");
  a_stretch_low: assert property ($fell(scl_oe_n) |-> !scl_in && selected_reg)
    else $error("stretch outside low phase");
  a_stretch_short: assert property (hold_reg < 4'hc)
    else $error("stretch too long");
  a_quiet_unmatched: assert property (!selected_reg |=> sda_oe_n || selected_reg)
    else $error("drove data while unaddressed");
  a_match_ack: assert property ($rose(selected_reg) |-> ##[0:40] !sda_oe_n)
    else $error("address not acknowledged");
  a_match_framed: assert property ($rose(selected_reg) |-> bus_busy_reg && interface_select)
    else $error("selected outside frame");
endmodule

bind sirs_slave sirs_chk i_sirs_chk (
  .clock(clock), .reset(reset), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .interface_select(interface_select),
  .address_lsb_strap(address_lsb_strap), .bus_busy_reg(bus_busy_reg), .selected_reg(selected_reg)
);

`default_nettype wire

// [dv/sirs_slave_tb.sv]
// Self-checking bench: a behavioural master runs write and read frames.
// Assumes the slave holds its own register bank and the lines have pull-ups.
`timescale 1ns/10ps
`default_nettype none

module sirs_slave_tb;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic       interface_select = 1'b1;
  logic       address_lsb_strap = 1'b0;
  logic       scl_in;
  logic       sda_in;
  logic       s_scl_oe_n;
  logic       s_sda_oe_n;
  logic       m_scl_oe_n;
  logic       m_sda_oe_n;
  logic       res_stb;
  logic [7:0] res_val;
  logic [7:0] mem [128];
  logic [7:0] exp_q [$];
  int         mismatches = 0;
  int         checked = 0;

  assign scl_in = s_scl_oe_n & m_scl_oe_n;
  assign sda_in = s_sda_oe_n & m_sda_oe_n;

  sirs_slave i_sirs_slave (
    .clock(clock), .reset(reset), .scl_in(scl_in), .scl_out(), .scl_oe_n(s_scl_oe_n),
    .sda_in(sda_in), .sda_out(), .sda_oe_n(s_sda_oe_n), .interface_select(interface_select),
    .address_lsb_strap(address_lsb_strap), .bus_busy_reg(), .selected_reg()
  );

  sirs_mst i_sirs_mst (
    .scl(scl_in), .sda(sda_in), .scl_oe_n(m_scl_oe_n), .sda_oe_n(m_sda_oe_n),
    .res_stb(res_stb), .res_val(res_val)
  );

  initial begin
    forever #10 clock = ~clock;
  end

  task automatic print_verdict();
    if (exp_q.size() != 0) mismatches++;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge res_stb) begin
    if (exp_q.size() == 0) begin
      mismatches++;
      $display("[FAIL] %0t extra %h none %h", $time, res_val, 8'h00);
    end else begin
      checked++;
      if (res_val !== exp_q[0]) begin
        mismatches++;
        $display("[FAIL] %0t got %h expected %h", $time, res_val, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
  end

  // Ack bytes expect 0, a refused address expects 1, read bytes expect data.
  task automatic xfer(input logic [6:0] bus_slave_address, input logic [7:0] sub, input int nw, input int nr);
    logic       hit;
    logic [6:0] a;
    logic [7:0] d;
    hit = interface_select && bus_slave_address == {6'h2e, address_lsb_strap};
    a = sub[6:0];
    i_sirs_mst.start();
    exp_q.push_back({7'h00, !hit});
    i_sirs_mst.xbyte({bus_slave_address, 2'b01}, 1'b0);
    if (hit) begin
      exp_q.push_back(8'h00);
      i_sirs_mst.xbyte({sub, 1'b1}, 1'b0);
      for (int i = 0; i < nw; i++) begin
        d = 8'($urandom);
        mem[a] = d;
        if (sub[7]) a++;
        exp_q.push_back(8'h00);
        i_sirs_mst.xbyte({d, 1'b1}, 1'b0);
      end
      if (nr > 0) begin
        i_sirs_mst.start();
        exp_q.push_back(8'h00);
        i_sirs_mst.xbyte({bus_slave_address, 2'b11}, 1'b0);
        for (int i = 0; i < nr; i++) begin
          exp_q.push_back(mem[a]);
          if (sub[7]) a++;
          i_sirs_mst.xbyte({8'hff, i == nr - 1}, 1'b1);
        end
      end
    end
    i_sirs_mst.stop();
  endtask

  initial begin
    #1000000;
    mismatches++;
    print_verdict();
  end

  initial begin
    void'($urandom(17));
    repeat (10) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    repeat (3) @(negedge clock);
    xfer(7'h5c, 8'h8a, 4, 0);
    xfer(7'h5c, 8'h8a, 0, 4);
    xfer(7'h5c, 8'h14, 3, 0);
    xfer(7'h5c, 8'h14, 0, 2);
    xfer(7'h5c, 8'hff, 2, 0);
    xfer(7'h5c, 8'hff, 0, 2);
    xfer(7'h5d, 8'h8a, 1, 0);
    @(negedge clock);
    address_lsb_strap = 1'b1;
    xfer(7'h5d, 8'h8a, 0, 2);
    xfer(7'h5d, 8'h20, 3, 0);
    xfer(7'h5d, 8'h20, 0, 2);
    xfer(7'h5c, 8'h80, 0, 1);
    @(negedge clock);
    interface_select = 1'b0;
    xfer(7'h5d, 8'h8a, 0, 1);
    @(negedge clock);
    interface_select = 1'b1;
    xfer(7'h5d, 8'h0a, 0, 1);
    print_verdict();
  end
endmodule

`default_nettype wire
